// [core/crd_defs.svh]
// Offsets, field positions, encodings and reset values of the descriptor framer
`ifndef CRD_DEFS_SVH
`define CRD_DEFS_SVH
// Register offsets (byte addresses)
`define CRD_REG_CTRL 8'h00
`define CRD_REG_STATUS 8'h04
`define CRD_REG_OBFF_RSV 8'h08
// Control bit positions and reset value
`define CRD_CTRL_RP_BIT 0
`define CRD_CTRL_ARI_BIT 1
`define CRD_CTRL_RESET 2'h0
// Descriptor field positions
`define CRD_TYPE_HI 78
`define CRD_TYPE_LO 75
`define CRD_TAG_HI 103
`define CRD_TAG_LO 96
`define CRD_FN_HI 111
`define CRD_FN_LO 104
`define CRD_BAR_HI 114
`define CRD_BAR_LO 112
`define CRD_APER_HI 120
`define CRD_APER_LO 115
`define CRD_TC_HI 123
`define CRD_TC_LO 121
`define CRD_ATTR_NS 124
`define CRD_ATTR_RO 125
`define CRD_ATTR_IDO 126
// Request type codes
`define CRD_TYPE_IO_RD 4'h2
`define CRD_TYPE_IO_WR 4'h3
`define CRD_TYPE_LAST_REQ 4'h7
`define CRD_TYPE_MSG 4'hC
`define CRD_TYPE_VDM 4'hD
`define CRD_TYPE_ATS 4'hE
// Window and message codes
`define CRD_BAR_ROM 3'h6
`define CRD_ROUTE_BY_ID 3'h2
`define CRD_OBFF_ACTIVE 4'hF
`define CRD_OBFF_MEMPATH 4'h1
`define CRD_OBFF_IDLE 4'h0
`endif

// [core/crd_desc_framer.sv]
// Completer request descriptor framer: builds the 16-byte descriptor of each request
`timescale 1ns/100ps
`include "crd_defs.svh"
module crd_desc_framer (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // Decoded request
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire crd_pkg::crd_req_code_t REQ_TYPE_IN,
  input wire logic [95:0] REQ_LOWER_IN,
  input wire logic [7:0] REQ_TAG_IN,
  input wire logic [2:0] REQ_TRAFFIC_CLASS_FIELD_IN,
  input wire logic [2:0] REQ_ATTR_IN,
  // Window match
  input wire logic MATCH_IS_VF_IN,
  input wire logic [1:0] MATCH_FUNC_IN,
  input wire logic [7:0] MATCH_ARI_FUNC_IN,
  input wire logic [2:0] MATCH_BAR_IN,
  input wire logic MATCH_BAR64_IN,
  input wire logic MATCH_ROM_IN,
  input wire logic [5:0] MATCH_APER_IN,
  input wire logic [5:0] MATCH_VF_APER_IN,
  // Message header
  input wire logic [7:0] MSG_CODE_IN,
  input wire logic [2:0] MSG_ROUTING_IN,
  input wire logic MSG_IS_LTR_IN,
  input wire logic MSG_IS_OBFF_IN,
  input wire logic [15:0] MSG_SNOOP_LAT_IN,
  input wire logic [15:0] MSG_NOSNOOP_LAT_IN,
  input wire logic [3:0] MSG_OBFF_CODE_IN,
  input wire logic [15:0] MSG_DEST_ID_IN,
  input wire logic [31:0] MSG_HDR_DW2_IN,
  input wire logic [31:0] MSG_HDR_DW3_IN,
  // Descriptor beat
  output crd_pkg::crd_desc_t DESC_OUT,
  output logic DESC_VALID_OUT,
  input wire logic DESC_READY_IN
);
  import crd_pkg::*;

  crd_state_t st;         // Registered state
  crd_state_t next_st;    // Next state
  logic take;             // Request accepted this cycle
  logic is_req;           // Memory, I/O or atomic request
  logic is_msg;           // Any message type
  logic ido_ok;           // IDO permitted for this type
  logic [7:0] target_fn;  // Mapped target function
  logic [2:0] matched_window_index; // Mapped window index
  logic [5:0] aperture;   // Mapped aperture
  logic [63:0] msg_low;   // Message-specific low bits
  logic obff_rsv;         // Reserved OBFF code seen

  // Window match mapping
  crd_window_map u_window_map (
    .root_port_mode_in(st.root_port_mode),
    .ari_en_in(st.ari_en),
    .match_is_vf_in(MATCH_IS_VF_IN),
    .match_func_in(MATCH_FUNC_IN),
    .match_ari_func_in(MATCH_ARI_FUNC_IN),
    .match_bar_in(MATCH_BAR_IN),
    .match_bar64_in(MATCH_BAR64_IN),
    .match_rom_in(MATCH_ROM_IN),
    .match_aper_in(MATCH_APER_IN),
    .match_vf_aper_in(MATCH_VF_APER_IN),
    .target_fn_out(target_fn),
    .matched_window_index_out(matched_window_index),
    .aperture_out(aperture)
  );

  // Message field packing
  crd_msg_pack u_msg_pack (
    .req_type_in(REQ_TYPE_IN),
    .routing_in(MSG_ROUTING_IN),
    .is_ltr_in(MSG_IS_LTR_IN),
    .is_obff_in(MSG_IS_OBFF_IN),
    .snoop_lat_in(MSG_SNOOP_LAT_IN),
    .nosnoop_lat_in(MSG_NOSNOOP_LAT_IN),
    .obff_code_in(MSG_OBFF_CODE_IN),
    .dest_id_in(MSG_DEST_ID_IN),
    .hdr_dw2_in(MSG_HDR_DW2_IN),
    .hdr_dw3_in(MSG_HDR_DW3_IN),
    .low_out(msg_low),
    .obff_rsv_out(obff_rsv)
  );

  // Single output stage; accept when empty or draining
  // One stage still moves a beat per cycle while the consumer keeps up
  assign REQ_READY_OUT = !st.valid || DESC_READY_IN;
  assign take = REQ_VALID_IN && REQ_READY_OUT;
  assign DESC_OUT = st.desc;
  assign DESC_VALID_OUT = st.valid;
  assign REG_RDATA_OUT = st.rdata;

  // Type classes decide which layout applies
  always_comb begin
    // Types up to locked read use the request layout
    is_req = (REQ_TYPE_IN <= `CRD_TYPE_LAST_REQ);
    // Three message types, each with its own low word
    is_msg = (REQ_TYPE_IN == `CRD_TYPE_MSG) || (REQ_TYPE_IN == `CRD_TYPE_VDM)
             || (REQ_TYPE_IN == `CRD_TYPE_ATS);
    // I/O is not a memory request, so no IDO there
    ido_ok = (is_req && (REQ_TYPE_IN != `CRD_TYPE_IO_RD) && (REQ_TYPE_IN != `CRD_TYPE_IO_WR)) || is_msg;
  end

  // Next state: descriptor build, counters and register port
  always_comb begin
    // Hold by default; only changed fields are named
    next_st = st;
    // Beat leaves when the consumer takes it
    if (st.valid && DESC_READY_IN) begin
      next_st.valid = 1'b0;
    end
    // New descriptor on every accepted request
    if (take) begin
      next_st.valid = 1'b1;
      // Zero first so fields undefined for the type stay clear
      next_st.desc = '0;
      // Address, count and requester ID pass through
      next_st.desc[95:0] = REQ_LOWER_IN;
      next_st.desc[`CRD_TYPE_HI:`CRD_TYPE_LO] = REQ_TYPE_IN;
      // Message layouts own the low 64 bits
      if (is_msg) begin
        next_st.desc[63:0] = msg_low;
      end
      // Tag always travels, even where the consumer may ignore it
      next_st.desc[`CRD_TAG_HI:`CRD_TAG_LO] = REQ_TAG_IN;
      // Function/code and window/routing share the same bits
      if (is_msg) begin
        next_st.desc[`CRD_FN_HI:`CRD_FN_LO] = MSG_CODE_IN;
        next_st.desc[`CRD_BAR_HI:`CRD_BAR_LO] = MSG_ROUTING_IN;
      end else if (is_req) begin
        next_st.desc[`CRD_FN_HI:`CRD_FN_LO] = target_fn;
        next_st.desc[`CRD_BAR_HI:`CRD_BAR_LO] = matched_window_index;
        next_st.desc[`CRD_APER_HI:`CRD_APER_LO] = aperture;
      end
      // Class and attributes apply to every type
      next_st.desc[`CRD_TC_HI:`CRD_TC_LO] = REQ_TRAFFIC_CLASS_FIELD_IN;
      next_st.desc[`CRD_ATTR_NS] = REQ_ATTR_IN[0];
      next_st.desc[`CRD_ATTR_RO] = REQ_ATTR_IN[1];
      // IDO masked where the type may not carry it
      next_st.desc[`CRD_ATTR_IDO] = REQ_ATTR_IN[2] && ido_ok;
      // Status bookkeeping, wraps
      next_st.pkt_cnt = st.pkt_cnt + 16'h0001;
      next_st.last_type = REQ_TYPE_IN;
      // Reserved OBFF codes are passed on and only counted
      if (is_msg && obff_rsv) begin
        next_st.obff_rsv_cnt = st.obff_rsv_cnt + 8'h01;
      end
    end
    // Control write; mode changes apply to the next request
    // A take in the same cycle still uses the old mode
    if (REG_WR_IN && (REG_ADDR_IN == `CRD_REG_CTRL)) begin
      next_st.root_port_mode = REG_WDATA_IN[`CRD_CTRL_RP_BIT];
      next_st.ari_en = REG_WDATA_IN[`CRD_CTRL_ARI_BIT];
    end
    // Read data stands for one cycle only
    next_st.rdata = 32'h0;
    // Reads see the state from before this edge
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `CRD_REG_CTRL: begin
          next_st.rdata = {30'h0, st.ari_en, st.root_port_mode};
        end
        `CRD_REG_STATUS: begin
          next_st.rdata = {11'h0, st.valid, st.last_type, st.pkt_cnt};
        end
        `CRD_REG_OBFF_RSV: begin
          next_st.rdata = {24'h0, st.obff_rsv_cnt};
        end
        default: begin
          // Unmapped reads return zero
          next_st.rdata = 32'h0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st <= '0;
      // Mode bits start from the control register's reset value
      st.root_port_mode <= 1'(`CRD_CTRL_RESET >> `CRD_CTRL_RP_BIT);
      st.ari_en <= 1'(`CRD_CTRL_RESET >> `CRD_CTRL_ARI_BIT);
    end else begin
      st <= next_st;
    end
  end

  // Checks triggered by a take look at the built beat one cycle after it
  // Tag lands in place one cycle after acceptance
  a_tag_placed: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    take |=> DESC_VALID_OUT && (DESC_OUT[`CRD_TAG_HI:`CRD_TAG_LO] == $past(REQ_TAG_IN)))
    else $error("tag not placed");

  // Without ARI the upper function bits stay clear
  a_fn_narrow: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && !st.ari_en) |=> (DESC_OUT[`CRD_FN_HI:107] == 5'h00)
    && (DESC_OUT[106:104] == {$past(MATCH_IS_VF_IN), $past(MATCH_FUNC_IN)}))
    else $error("function field wrong");

  // Root port reports window zero
  a_rp_window_zero: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && st.root_port_mode) |=> (DESC_OUT[`CRD_BAR_HI:`CRD_BAR_LO] == 3'h0))
    else $error("window index not zero in root port");

  // Wide pair reports its even member
  a_pair_even: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && MATCH_BAR64_IN && !MATCH_ROM_IN) |=> (DESC_OUT[`CRD_BAR_LO] == 1'b0))
    else $error("wide window index odd");

  // Class and attributes carried; IDO only for memory requests and messages
  a_class_attr: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    take |=> (DESC_OUT[`CRD_TC_HI:`CRD_TC_LO] == $past(REQ_TRAFFIC_CLASS_FIELD_IN))
    && (DESC_OUT[`CRD_ATTR_RO:`CRD_ATTR_NS] == $past(REQ_ATTR_IN[1:0]))
    && (DESC_OUT[`CRD_ATTR_IDO] == ($past(REQ_ATTR_IN[2]) && ($past(REQ_TYPE_IN) != `CRD_TYPE_IO_RD)
    && ($past(REQ_TYPE_IN) != `CRD_TYPE_IO_WR) && (($past(REQ_TYPE_IN) <= `CRD_TYPE_LAST_REQ)
    || (($past(REQ_TYPE_IN) >= `CRD_TYPE_MSG) && ($past(REQ_TYPE_IN) <= `CRD_TYPE_ATS))))))
    else $error("class or attributes wrong");

  // Latencies in the low word for LTR
  a_ltr_latency: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && (REQ_TYPE_IN == `CRD_TYPE_MSG) && MSG_IS_LTR_IN)
    |=> (DESC_OUT[31:0] == {$past(MSG_NOSNOOP_LAT_IN), $past(MSG_SNOOP_LAT_IN)}))
    else $error("latency fields wrong");

  // Code and routing for every message
  a_msg_code_route: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_msg) |=> (DESC_OUT[`CRD_FN_HI:`CRD_FN_LO] == $past(MSG_CODE_IN))
    && (DESC_OUT[`CRD_BAR_HI:`CRD_BAR_LO] == $past(MSG_ROUTING_IN)))
    else $error("message code or routing wrong");

  // ATS header dwords in order
  a_ats_header: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && (REQ_TYPE_IN == `CRD_TYPE_ATS))
    |=> (DESC_OUT[63:0] == {$past(MSG_HDR_DW3_IN), $past(MSG_HDR_DW2_IN)}))
    else $error("ATS header wrong");

  // Routed-by-ID vendor message carries destination
  a_vdm_dest: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && (REQ_TYPE_IN == `CRD_TYPE_VDM) && (MSG_ROUTING_IN == `CRD_ROUTE_BY_ID))
    |=> (DESC_OUT[15:0] == $past(MSG_DEST_ID_IN)) && (DESC_OUT[63:32] == $past(MSG_HDR_DW3_IN)))
    else $error("vendor message fields wrong");

  // Stalled beat holds steady into the next cycle
  a_beat_holds: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (DESC_VALID_OUT && !DESC_READY_IN) |=> DESC_VALID_OUT && $stable(DESC_OUT))
    else $error("descriptor changed while stalled");

  // Type field follows the request
  a_type_field: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    take |=> (DESC_OUT[`CRD_TYPE_HI:`CRD_TYPE_LO] == $past(REQ_TYPE_IN)))
    else $error("type field wrong");

  // ARI hands over the full eight-bit function number
  a_fn_wide: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && st.ari_en) |=> (DESC_OUT[`CRD_FN_HI:`CRD_FN_LO] == $past(MATCH_ARI_FUNC_IN)))
    else $error("wide function field wrong");

  // Expansion ROM hit has its own window code
  a_rom_window: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && !st.root_port_mode && MATCH_ROM_IN) |=> (DESC_OUT[`CRD_BAR_HI:`CRD_BAR_LO] == 3'h6))
    else $error("ROM window code wrong");

  // Single window reports its own number
  a_plain_window: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req && !st.root_port_mode && !MATCH_ROM_IN && !MATCH_BAR64_IN)
    |=> (DESC_OUT[`CRD_BAR_HI:`CRD_BAR_LO] == $past(MATCH_BAR_IN)))
    else $error("window index wrong");

  // Aperture of the window, per function for virtual functions
  a_aperture: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_req) |=> (DESC_OUT[`CRD_APER_HI:`CRD_APER_LO]
    == ($past(MATCH_IS_VF_IN) ? $past(MATCH_VF_APER_IN) : $past(MATCH_APER_IN))))
    else $error("aperture wrong");

  // OBFF code passed as received, reserved ones too
  a_obff_code: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && (REQ_TYPE_IN == `CRD_TYPE_MSG) && MSG_IS_OBFF_IN)
    |=> (DESC_OUT[35:32] == $past(MSG_OBFF_CODE_IN)))
    else $error("OBFF code wrong");

  // Messages leave the aperture bits clear
  a_msg_no_aper: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && is_msg) |=> (DESC_OUT[`CRD_APER_HI:`CRD_APER_LO] == 6'h00))
    else $error("message aperture not clear");

  // Types outside both layouts carry no function, window or aperture
  a_other_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && !is_req && !is_msg) |=> (DESC_OUT[`CRD_APER_HI:`CRD_FN_LO] == 17'h00000))
    else $error("unused fields not clear");

  // Request layouts pass the lower bits through
  a_lower_pass: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (take && !is_msg) |=> (DESC_OUT[63:0] == $past(REQ_LOWER_IN[63:0])))
    else $error("lower bits changed");

  // Spare top bit of the descriptor stays clear
  a_top_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    DESC_VALID_OUT |-> !DESC_OUT[127])
    else $error("top bit set");

  // Taken beat leaves unless a new one follows
  a_beat_leaves: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (DESC_VALID_OUT && DESC_READY_IN && !take) |=> !DESC_VALID_OUT)
    else $error("beat not released");
endmodule : crd_desc_framer

// [core/crd_msg_pack.sv]
// Packs the message-specific low 64 descriptor bits
`timescale 1ns/100ps
`include "crd_defs.svh"
module crd_msg_pack (
  // Message header fields
  input wire crd_pkg::crd_req_code_t req_type_in,
  input wire logic [2:0] routing_in,
  input wire logic is_ltr_in,
  input wire logic is_obff_in,
  input wire logic [15:0] snoop_lat_in,
  input wire logic [15:0] nosnoop_lat_in,
  input wire logic [3:0] obff_code_in,
  input wire logic [15:0] dest_id_in,
  input wire logic [31:0] hdr_dw2_in,
  input wire logic [31:0] hdr_dw3_in,
  // Packed result
  output logic [63:0] low_out,
  output logic obff_rsv_out
);
  import crd_pkg::*;

  // Layout depends on the request type
  always_comb begin
    low_out = 64'h0;
    obff_rsv_out = 1'b0;
    case (req_type_in)
      `CRD_TYPE_VDM: begin
        low_out[63:32] = hdr_dw3_in;
        // Destination only when routed by ID
        if (routing_in == `CRD_ROUTE_BY_ID) begin
          low_out[15:0] = dest_id_in;
        end
      end
      `CRD_TYPE_ATS: begin
        low_out = {hdr_dw3_in, hdr_dw2_in};
      end
      `CRD_TYPE_MSG: begin
        if (is_ltr_in) begin
          low_out[31:0] = {nosnoop_lat_in, snoop_lat_in};
        end
        if (is_obff_in) begin
          low_out[35:32] = obff_code_in;
          obff_rsv_out = (obff_code_in != `CRD_OBFF_ACTIVE) && (obff_code_in != `CRD_OBFF_MEMPATH)
                         && (obff_code_in != `CRD_OBFF_IDLE);
        end
      end
      default: begin
        low_out = 64'h0;
      end
    endcase
  end
endmodule : crd_msg_pack

// [core/crd_pkg.sv]
// Types shared by the descriptor framer modules
package crd_pkg;
  typedef logic [3:0] crd_req_code_t;   // Request type code
  typedef logic [127:0] crd_desc_t;     // One 16-byte descriptor
  // Complete state of the framer
  typedef struct packed {
    crd_desc_t desc;
    logic valid;
    logic root_port_mode;
    logic ari_en;
    logic [15:0] pkt_cnt;
    crd_req_code_t last_type;
    logic [7:0] obff_rsv_cnt;
    logic [31:0] rdata;
  } crd_state_t;
endpackage : crd_pkg

// [core/crd_window_map.sv]
// Maps the address-window match onto target function, window index and aperture
`timescale 1ns/100ps
`include "crd_defs.svh"
module crd_window_map (
  // Mode
  input wire logic root_port_mode_in,
  input wire logic ari_en_in,
  // Match result
  input wire logic match_is_vf_in,
  input wire logic [1:0] match_func_in,
  input wire logic [7:0] match_ari_func_in,
  input wire logic [2:0] match_bar_in,
  input wire logic match_bar64_in,
  input wire logic match_rom_in,
  input wire logic [5:0] match_aper_in,
  input wire logic [5:0] match_vf_aper_in,
  // Mapped fields
  output logic [7:0] target_fn_out,
  output logic [2:0] matched_window_index_out,
  output logic [5:0] aperture_out
);
  import crd_pkg::*;

  // Pure mapping, no state
  always_comb begin
    // Full eight bits only with alternative routing-ID, else codes 0..7
    if (ari_en_in) begin
      target_fn_out = match_ari_func_in;
    end else begin
      target_fn_out = {5'h00, match_is_vf_in, match_func_in};
    end
    // Root port always reports window zero
    if (root_port_mode_in) begin
      matched_window_index_out = 3'h0;
    end else if (match_rom_in) begin
      matched_window_index_out = `CRD_BAR_ROM;
    end else if (match_bar64_in) begin
      matched_window_index_out = {match_bar_in[2:1], 1'b0};
    end else begin
      matched_window_index_out = match_bar_in;
    end
    // Per-function size for virtual functions, not the whole window
    aperture_out = match_is_vf_in ? match_vf_aper_in : match_aper_in;
  end
endmodule : crd_window_map

// [tb/crd_desc_framer_tb.sv]
// Self-checking bench of the descriptor framer
`timescale 1ns/100ps
`include "crd_defs.svh"
module crd_desc_framer_tb;
  import crd_pkg::*;
  // One ordinary request: inputs and expected bits 127:96
  typedef struct packed {
    crd_req_code_t ty;
    logic [7:0] tag;
    logic [2:0] tc;
    logic [2:0] at;
    logic vf;
    logic [1:0] fn;
    logic [2:0] bar;
    logic b64;
    logic rom;
    logic [31:0] hi;
  } crd_row_t;
  localparam int N = 8;
  crd_row_t rows [N] = '{
    '{4'h0, 8'h11, 3'h3, 3'h7, 1'h0, 2'h2, 3'h1, 1'h0, 1'h0, 32'h76610211},
    '{4'h2, 8'hFF, 3'h7, 3'h7, 1'h1, 2'h3, 3'h5, 1'h0, 1'h0, 32'h3E2D07FF},
    '{4'h1, 8'h00, 3'h0, 3'h1, 1'h0, 2'h0, 3'h3, 1'h1, 1'h0, 32'h10620000},
    '{4'h6, 8'h80, 3'h1, 3'h4, 1'h1, 2'h0, 3'h5, 1'h1, 1'h0, 32'h422C0480},
    '{4'h3, 8'h5A, 3'h2, 3'h4, 1'h0, 2'h1, 3'h0, 1'h0, 1'h1, 32'h0466015A},
    '{4'h7, 8'h33, 3'h5, 3'h2, 1'h0, 2'h3, 3'h4, 1'h0, 1'h0, 32'h2A640333},
    '{4'h8, 8'h44, 3'h6, 3'h7, 1'h0, 2'h1, 3'h2, 1'h0, 1'h0, 32'h3C000044},
    '{4'hF, 8'h01, 3'h0, 3'h4, 1'h0, 2'h0, 3'h1, 1'h0, 1'h0, 32'h00000001}};
  // Clock, reset, register port
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] rwd = 32'h0;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [31:0] rdat;
  // Request side
  logic rv = 1'b0;
  logic rdy;
  crd_req_code_t rty = 4'h0;
  logic [95:0] lower = 96'h0123_4567_89AB_CDEF_FEDC_BA98; // Fixed payload of bits 95:0
  logic [7:0] tag = 8'h00;
  logic [2:0] tcf = 3'h0;
  logic [2:0] attr = 3'h0;
  // Window match, apertures held fixed
  logic mvf = 1'b0;
  logic [1:0] mfn = 2'h0;
  logic [7:0] mari = 8'h00;
  logic [2:0] mbar = 3'h0;
  logic mb64 = 1'b0;
  logic mrom = 1'b0;
  // Message header
  logic [7:0] mcode = 8'h00;
  logic [2:0] mroute = 3'h0;
  logic mltr = 1'b0;
  logic mobff = 1'b0;
  logic [3:0] mobc = 4'h0;
  logic [15:0] mdest = 16'h1234;
  logic [31:0] mdw2 = 32'h01234567;
  logic [31:0] mdw3 = 32'hCAFEF00D;
  // Descriptor side and partner state
  crd_desc_t dout;
  logic dvalid;
  logic dready;
  logic stall = 1'b0;
  logic [13:0] cpl;
  logic [7:0] ur;
  int fail_count = 0;
  int compares = 0;
  int cnt = 0; // Requests handed over so far

  always #2.5 clk = ~clk;

  crd_desc_framer DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(ra), .REG_WDATA_IN(rwd),
    .REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RDATA_OUT(rdat), .REQ_VALID_IN(rv), .REQ_READY_OUT(rdy),
    .REQ_TYPE_IN(rty), .REQ_LOWER_IN(lower), .REQ_TAG_IN(tag), .REQ_TRAFFIC_CLASS_FIELD_IN(tcf),
    .REQ_ATTR_IN(attr), .MATCH_IS_VF_IN(mvf), .MATCH_FUNC_IN(mfn), .MATCH_ARI_FUNC_IN(mari),
    .MATCH_BAR_IN(mbar), .MATCH_BAR64_IN(mb64), .MATCH_ROM_IN(mrom), .MATCH_APER_IN(6'h0C),
    .MATCH_VF_APER_IN(6'h05), .MSG_CODE_IN(mcode), .MSG_ROUTING_IN(mroute), .MSG_IS_LTR_IN(mltr),
    .MSG_IS_OBFF_IN(mobff), .MSG_SNOOP_LAT_IN(16'hAAAA), .MSG_NOSNOOP_LAT_IN(16'hBBBB),
    .MSG_OBFF_CODE_IN(mobc), .MSG_DEST_ID_IN(mdest), .MSG_HDR_DW2_IN(mdw2), .MSG_HDR_DW3_IN(mdw3),
    .DESC_OUT(dout), .DESC_VALID_OUT(dvalid), .DESC_READY_IN(dready));

  crd_user_sink u_sink (.clk_in(clk), .rst_in(rst), .desc_in(dout), .valid_in(dvalid),
    .ready_out(dready), .stall_in(stall), .cpl_out(cpl), .ur_cnt_out(ur));

  // Compare and count
  task automatic chk(string nm, logic [127:0] s, logic [127:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Whole expected descriptor: type into 78:75, message bits over 63:0
  function automatic logic [127:0] mk(crd_req_code_t t, logic [31:0] hi, logic [63:0] lo, logic msg);
    logic [95:0] l;
    l = lower;
    l[78:75] = t;
    if (msg) begin
      l[63:0] = lo;
    end
    return {hi, l};
  endfunction : mk

  // Register write, one cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr

  // Register read; data stands only in the following cycle
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(posedge clk);
    chk("rdata", rdat, e);
  endtask : rd

  // Hold a request until the edge that takes it
  task automatic put(crd_req_code_t t, logic [7:0] tg, logic [2:0] tc, logic [2:0] at);
    @(posedge clk);
    rv <= 1'b1;
    rty <= t;
    tag <= tg;
    tcf <= tc;
    attr <= at;
    @(posedge clk);
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
    rv <= 1'b0;
    cnt++;
  endtask : put

  // Wait for the beat to be consumed, then compare it
  task automatic get(logic [127:0] e);
    @(posedge clk);
    for (int i = 0; i < 50 && !(dvalid === 1'b1 && dready === 1'b1); i++) @(posedge clk);
    chk("desc", dout, e);
  endtask : get

  // Load a row's window match and send it
  task automatic row_put(crd_row_t r);
    mvf <= r.vf;
    mfn <= r.fn;
    mbar <= r.bar;
    mb64 <= r.b64;
    mrom <= r.rom;
    put(r.ty, r.tag, r.tc, r.at);
  endtask : row_put

  // Message with IDO set, which is legal for messages
  task automatic msg(crd_req_code_t t, logic [7:0] c, logic [2:0] r, logic [31:0] hi, logic [63:0] lo);
    mcode <= c;
    mroute <= r;
    put(t, 8'h00, 3'h0, 3'h4);
    get(mk(t, hi, lo, 1'b1));
  endtask : msg

  // Verdict
  task end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    chk("idle", {dvalid, rdy, rdat, dout}, {2'b01, 32'h0, 128'h0});
    @(posedge clk);
    rst <= 1'b0;
    rd(`CRD_REG_CTRL, 32'h0);
    // Ordinary requests
    for (int k = 0; k < N; k++) begin
      row_put(rows[k]);
      get(mk(rows[k].ty, rows[k].hi, 64'h0, 1'b0));
    end
    chk("cpl", cpl, 14'h1533);
    // Root port forces window index zero
    wr(`CRD_REG_CTRL, 32'h1);
    row_put('{4'h0, 8'h22, 3'h0, 3'h0, 1'h0, 2'h1, 3'h3, 1'h0, 1'h0, 32'h0});
    get(mk(4'h0, 32'h00600122, 64'h0, 1'b0));
    // Alternative routing IDs give all eight function bits
    wr(`CRD_REG_CTRL, 32'h2);
    rd(`CRD_REG_CTRL, 32'h2);
    mari <= 8'hA5;
    row_put('{4'h0, 8'h23, 3'h0, 3'h0, 1'h1, 2'h2, 3'h3, 1'h0, 1'h0, 32'h0});
    get(mk(4'h0, 32'h002BA523, 64'h0, 1'b0));
    wr(`CRD_REG_CTRL, 32'h0);
    // Latency message
    mltr <= 1'b1;
    msg(4'hC, 8'h10, 3'h4, 32'h40041000, 64'h00000000BBBBAAAA);
    mltr <= 1'b0;
    mobff <= 1'b1;
    // The three defined OBFF codes F, 1 and 0, then reserved code 5
    foreach (rows[k]) begin
      if (k < 4) begin
        mobc <= 4'(16'h501F >> (k * 4));
        msg(4'hC, 8'h12, 3'h3, 32'h40031200, {28'h0, 4'(16'h501F >> (k * 4)), 32'h0});
      end
    end
    rd(`CRD_REG_OBFF_RSV, 32'h1);
    mobff <= 1'b0;
    msg(4'hC, 8'hFF, 3'h0, 32'h4000FF00, 64'h0);
    // Partner counts on the edge that takes the beat
    @(posedge clk);
    chk("ur", ur, 8'h01);
    // Vendor message, routed by ID and not, then an ATS message
    msg(4'hD, 8'h7E, 3'h2, 32'h40027E00, {32'hCAFEF00D, 32'h00001234});
    msg(4'hD, 8'h7E, 3'h0, 32'h40007E00, {32'hCAFEF00D, 32'h0});
    msg(4'hE, 8'h01, 3'h2, 32'h40020100, {32'hCAFEF00D, 32'h01234567});
    // Consumer stalls: beat holds, next request refused
    stall <= 1'b1;
    row_put(rows[0]);
    fork
      row_put(rows[3]);
      begin
        repeat (3) begin
          @(posedge clk);
          chk("held", {rdy, dout}, {1'b0, mk(rows[0].ty, rows[0].hi, 64'h0, 1'b0)});
        end
        stall <= 1'b0;
      end
    join
    get(mk(rows[3].ty, rows[3].hi, 64'h0, 1'b0));
    rd(`CRD_REG_STATUS, {12'h0, 4'h6, cnt[15:0]});
    rd(8'h0C, 32'h0);
    // Reset in mid-run clears mode bits and status
    wr(`CRD_REG_CTRL, 32'h3);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(`CRD_REG_CTRL, 32'h0);
    rd(`CRD_REG_STATUS, 32'h0);
    chk("rst", {dvalid, rdy}, 2'b01);
    end_sim();
  end
endmodule : crd_desc_framer_tb

// [tb/crd_user_sink.sv]
// Model of the user completer logic that takes descriptor beats
`timescale 1ns/100ps
module crd_user_sink (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Descriptor stream
  input wire logic [127:0] desc_in,
  input wire logic valid_in,
  output logic ready_out,
  // Bench control
  input wire logic stall_in,
  // Kept completion fields and unsupported-code count
  output logic [13:0] cpl_out,
  output logic [7:0] ur_cnt_out
);
  logic [3:0] ty; // Request type of the beat
  assign ty = desc_in[78:75];
  // Back-pressure only when the bench asks for it
  assign ready_out = !stall_in;
  // Only fields defined for the beat's type are looked at
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpl_out <= 14'h0000;
      ur_cnt_out <= 8'h00;
    end else if (valid_in && ready_out) begin
      // Reads and atomics need tag, class and attributes back
      if (ty == 4'h0 || ty == 4'h2 || (ty >= 4'h4 && ty <= 4'h7)) begin
        cpl_out <= {desc_in[126:121], desc_in[103:96]};
      end
      // Only LTR and OBFF codes known; a counter stands in for the error pulse
      if (ty == 4'hC && desc_in[111:104] != 8'h10 && desc_in[111:104] != 8'h12) begin
        ur_cnt_out <= ur_cnt_out + 8'h01;
      end
    end
  end
endmodule : crd_user_sink
